/* File: rtl/crx_pkg.sv */
/*
  crx_pkg: register offsets, field positions, reset value and the packed
  layouts of a message object and of a received or outgoing frame.
  Assumes a 32-bit register data port carrying 16-bit registers.
*/
package crx_pkg;
  localparam int OBJ_COUNT = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_W = 6;
  localparam int SEL_W = 8;
  localparam int REG_W = 16;
  localparam int ID_W = 29;
  localparam int HI_W = 13;
  localparam int DLC_W = 4;
  localparam int PAY_W = 64;
  // a standard identifier occupies ident[28:18]
  localparam int STD_LOW = 18;

  // register byte offsets
  localparam logic [7:0] OFS_SELECT = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_FILT_LO = 8'h08;
  localparam logic [7:0] OFS_FILT_HI = 8'h0C;
  localparam logic [7:0] OFS_IDENT_LO = 8'h10;
  localparam logic [7:0] OFS_IDENT_HI = 8'h14;
  localparam logic [7:0] OFS_CONTROL = 8'h18;
  localparam logic [7:0] OFS_PAY_A1 = 8'h1C;
  localparam logic [7:0] OFS_PAY_A2 = 8'h20;
  localparam logic [7:0] OFS_PAY_B1 = 8'h24;
  localparam logic [7:0] OFS_PAY_B2 = 8'h28;
  localparam logic [7:0] OFS_PENDING = 8'h2C;
  localparam logic [7:0] OFS_FRESH = 8'h30;
  localparam logic [7:0] OFS_IRQ = 8'h34;

  // transfer select bits
  localparam int SEL_STORE = 7;
  localparam int SEL_MASK = 6;
  localparam int SEL_ARB = 5;
  localparam int SEL_CTRL = 4;
  localparam int SEL_CLR_IRQ = 3;
  localparam int SEL_PEND = 2;
  localparam int SEL_DATA_A = 1;
  localparam int SEL_DATA_B = 0;
  // upper filter and upper identifier words
  localparam int FH_LONG = 15;
  localparam int FH_WAY = 14;
  localparam int IH_USE = 15;
  localparam int IH_LONG = 14;
  localparam int IH_WAY = 13;
  // object control word
  localparam int CT_FRESH = 15;
  localparam int CT_OVER = 14;
  localparam int CT_IRQ = 13;
  localparam int CT_FILT = 12;
  localparam int CT_TXIE = 11;
  localparam int CT_RECEIVE_IRQ_ENABLE = 10;
  localparam int CT_AUTO = 9;
  localparam int CT_SEND = 8;
  localparam int CT_LAST = 7;

  localparam logic [15:0] REG_RESET = 16'h0000;

  typedef struct packed {
    logic [ID_W-1:0] filter_bits;
    logic mask_on_long_id;
    logic mask_on_way_bit;
  } crx_mask_t;

  typedef struct packed {
    logic [ID_W-1:0] ident;
    logic long_identifier_flag;
    logic way_bit;
    logic object_in_use;
  } crx_arb_t;

  typedef struct packed {
    logic fresh_content_flag;
    logic overrun_flag;
    logic irq_waiting;
    logic filter_enable;
    logic send_irq_enable;
    logic receive_irq_enable;
    logic auto_answer_enable;
    logic send_pending;
    logic last_in_chain;
    logic [DLC_W-1:0] dlc;
  } crx_ctl_t;

  typedef struct packed {
    crx_mask_t mask;
    crx_arb_t arb;
    crx_ctl_t ctl;
    logic [PAY_W-1:0] payload;
  } crx_obj_t;

  typedef struct packed {
    logic [ID_W-1:0] ident;
    logic long_identifier_flag;
    logic remote;
    logic [DLC_W-1:0] dlc;
    logic [PAY_W-1:0] payload;
  } crx_frame_t;
endpackage : crx_pkg

/* File: rtl/crx_match.sv */
/*
  crx_match: acceptance test of one message object against the
  arbitration field of an incoming frame. Purely combinational; assumes
  the frame fields are stable while the caller samples the result.
*/
module crx_match (
  // object under test
  input wire crx_pkg::crx_obj_t obj,
  // incoming frame
  input wire crx_pkg::crx_frame_t frame,
  // result
  output logic hit
);
  logic [crx_pkg::ID_W-1:0] care;
  logic long_care;
  logic way_care;

  always_comb begin
    if (obj.ctl.filter_enable) begin
      care = obj.mask.filter_bits;
      long_care = obj.mask.mask_on_long_id;
      way_care = obj.mask.mask_on_way_bit;
    end else begin
      care = '1;
      long_care = 1'b1;
      way_care = 1'b1;
    end
    // standard ids only use the top eleven identifier bits
    if (!frame.long_identifier_flag) begin
      care[crx_pkg::STD_LOW-1:0] = '0;
    end
    hit = obj.arb.object_in_use
      && (((obj.arb.ident ^ frame.ident) & care) == '0)
      && (!long_care || (obj.arb.long_identifier_flag == frame.long_identifier_flag))
      && (!way_care || (obj.arb.way_bit == frame.remote));
  end
endmodule : crx_match

/* File: rtl/crx_handler.sv */
/*
  crx_handler: message object store with interface register set,
  acceptance scan, remote frame handling and transmit priority.
  Assumes the receive shifter and the transmit engine run on CORE_CLK
  and present whole frames; the register master never waits.
*/
// Decided for this implementation: the register offsets and strobed register access.
module crx_handler #(
  parameter int NUM_OBJ = crx_pkg::OBJ_COUNT
) (
  // clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic CE,
  // register port
  input wire logic [crx_pkg::ADDR_W-1:0] ADDR,
  input wire logic [crx_pkg::DATA_W-1:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [crx_pkg::DATA_W-1:0] RD_DATA,
  // completed frame from the receive shifter
  input wire logic RX_VALID,
  input wire crx_pkg::crx_frame_t RX_FRAME,
  output logic RX_MATCH,
  output logic [crx_pkg::NUM_W-1:0] RX_OBJECT,
  // transmit engine
  output logic TX_REQUEST,
  output logic [crx_pkg::NUM_W-1:0] TX_OBJECT,
  output crx_pkg::crx_frame_t TX_FRAME,
  input wire logic TX_DONE,
  input wire logic [crx_pkg::NUM_W-1:0] TX_DONE_OBJECT
);
  localparam int IW = $clog2(NUM_OBJ);

  generate
    if (NUM_OBJ < 2 || NUM_OBJ > crx_pkg::OBJ_COUNT) begin : g_bad_count
      $error("NUM_OBJ must lie between 2 and 32");
    end
  endgenerate

  crx_pkg::crx_obj_t obj [NUM_OBJ];
  crx_pkg::crx_obj_t ifc;
  logic [crx_pkg::SEL_W-1:0] sel;
  logic [crx_pkg::NUM_W-1:0] object_select;
  logic [NUM_OBJ-1:0] hit;
  logic [NUM_OBJ-1:0] pend;
  logic [NUM_OBJ-1:0] fresh_vec;
  logic [NUM_OBJ-1:0] irq_vec;
  logic rx_found;
  logic [IW-1:0] rx_idx;
  logic rx_go;
  logic tx_found;
  logic [IW-1:0] tx_idx;
  logic cmd_go;
  logic [crx_pkg::NUM_W-1:0] cmd_num;
  logic [IW-1:0] cmd_idx;
  logic [crx_pkg::DATA_W-1:0] next_rd;

  // copies the groups chosen by the select byte from s into d
  function automatic crx_pkg::crx_obj_t merge(crx_pkg::crx_obj_t d,
                                              crx_pkg::crx_obj_t s,
                                              logic [crx_pkg::SEL_W-1:0] m);
    crx_pkg::crx_obj_t r;
    r = d;
    if (m[crx_pkg::SEL_MASK]) begin
      r.mask = s.mask;
    end
    if (m[crx_pkg::SEL_ARB]) begin
      r.arb = s.arb;
    end
    if (m[crx_pkg::SEL_CTRL]) begin
      r.ctl = s.ctl;
    end
    if (m[crx_pkg::SEL_DATA_A]) begin
      r.payload[crx_pkg::PAY_W/2-1:0] = s.payload[crx_pkg::PAY_W/2-1:0];
    end
    if (m[crx_pkg::SEL_DATA_B]) begin
      r.payload[crx_pkg::PAY_W-1:crx_pkg::PAY_W/2] = s.payload[crx_pkg::PAY_W-1:crx_pkg::PAY_W/2];
    end
    return r;
  endfunction : merge

  function automatic logic [crx_pkg::REG_W-1:0] ctl_word(crx_pkg::crx_ctl_t c);
    logic [crx_pkg::REG_W-1:0] w;
    w = crx_pkg::REG_RESET;
    w[crx_pkg::CT_FRESH] = c.fresh_content_flag;
    w[crx_pkg::CT_OVER] = c.overrun_flag;
    w[crx_pkg::CT_IRQ] = c.irq_waiting;
    w[crx_pkg::CT_FILT] = c.filter_enable;
    w[crx_pkg::CT_TXIE] = c.send_irq_enable;
    w[crx_pkg::CT_RECEIVE_IRQ_ENABLE] = c.receive_irq_enable;
    w[crx_pkg::CT_AUTO] = c.auto_answer_enable;
    w[crx_pkg::CT_SEND] = c.send_pending;
    w[crx_pkg::CT_LAST] = c.last_in_chain;
    w[crx_pkg::DLC_W-1:0] = c.dlc;
    return w;
  endfunction : ctl_word

  assign cmd_num = WR_DATA[crx_pkg::NUM_W-1:0];
  assign cmd_idx = IW'(cmd_num - 6'h01);
  // numbers outside 1..NUM_OBJ start no transfer at all
  assign cmd_go = CE && WR_STB && (ADDR == crx_pkg::OFS_COMMAND)
    && (cmd_num != '0) && (cmd_num <= crx_pkg::NUM_W'(NUM_OBJ));
  assign rx_go = CE && RX_VALID && rx_found;

  // lowest numbered hit wins; walking down leaves the lowest last
  always_comb begin
    rx_found = 1'b0;
    rx_idx = '0;
    for (int i = NUM_OBJ - 1; i >= 0; i--) begin
      if (hit[i]) begin
        rx_found = 1'b1;
        rx_idx = IW'(i);
      end
    end
  end

  always_comb begin
    tx_found = 1'b0;
    tx_idx = '0;
    for (int i = NUM_OBJ - 1; i >= 0; i--) begin
      if (pend[i]) begin
        tx_found = 1'b1;
        tx_idx = IW'(i);
      end
    end
  end

  generate
    for (genvar g = 0; g < NUM_OBJ; g++) begin : g_obj
      logic mine;
      logic answer;
      logic take;
      logic done;

      crx_match u_match (
        .obj(obj[g]),
        .frame(RX_FRAME),
        .hit(hit[g])
      );

      assign pend[g] = obj[g].arb.object_in_use && obj[g].ctl.send_pending;
      assign fresh_vec[g] = obj[g].ctl.fresh_content_flag;
      assign irq_vec[g] = obj[g].ctl.irq_waiting;
      assign mine = rx_go && (rx_idx == IW'(g));
      assign done = CE && TX_DONE && (TX_DONE_OBJECT == crx_pkg::NUM_W'(g + 1));
      assign answer = mine && RX_FRAME.remote && obj[g].arb.way_bit
        && obj[g].ctl.auto_answer_enable;
      // remote into a transmit object without auto answer is taken only with filter on; else dropped
      assign take = mine && (RX_FRAME.remote
        ? (obj[g].arb.way_bit && !obj[g].ctl.auto_answer_enable
           && obj[g].ctl.filter_enable)
        : 1'b1);

      always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
          obj[g] <= '0;
        end else if (CE) begin
          if (cmd_go && (cmd_idx == IW'(g))) begin
            if (sel[crx_pkg::SEL_STORE]) begin
              obj[g] <= merge(obj[g], ifc, sel);
              if (sel[crx_pkg::SEL_PEND]) begin
                obj[g].ctl.send_pending <= 1'b1;
              end
            end else begin
              if (sel[crx_pkg::SEL_CLR_IRQ]) begin
                obj[g].ctl.irq_waiting <= 1'b0;
              end
              if (sel[crx_pkg::SEL_PEND]) begin
                obj[g].ctl.fresh_content_flag <= 1'b0;
              end
            end
          end
          if (done) begin
            obj[g].ctl.send_pending <= 1'b0;
            if (obj[g].ctl.send_irq_enable) begin
              obj[g].ctl.irq_waiting <= 1'b1;
            end
          end
          // frame events come last so they beat a same-cycle command or send completion
          if (answer) begin
            obj[g].ctl.send_pending <= 1'b1;
          end
          if (take) begin
            obj[g].ctl.send_pending <= 1'b0;
            obj[g].arb.ident <= RX_FRAME.ident;
            obj[g].arb.long_identifier_flag <= RX_FRAME.long_identifier_flag;
            obj[g].ctl.dlc <= RX_FRAME.dlc;
            obj[g].ctl.fresh_content_flag <= 1'b1;
            if (obj[g].ctl.fresh_content_flag) begin
              obj[g].ctl.overrun_flag <= 1'b1;
            end
            if (obj[g].ctl.receive_irq_enable) begin
              obj[g].ctl.irq_waiting <= 1'b1;
            end
            // a remote request leaves the payload for software to fill
            if (!RX_FRAME.remote) begin
              obj[g].payload <= RX_FRAME.payload;
            end
          end
        end
      end
    end
  endgenerate

  // interface register set and command handling
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ifc <= '0;
      sel <= '0;
      object_select <= '0;
    end else if (CE) begin
      if (WR_STB) begin
        case (ADDR)
          crx_pkg::OFS_SELECT: begin
            sel <= WR_DATA[crx_pkg::SEL_W-1:0];
          end
          crx_pkg::OFS_FILT_LO: begin
            ifc.mask.filter_bits[crx_pkg::REG_W-1:0] <= WR_DATA[crx_pkg::REG_W-1:0];
          end
          crx_pkg::OFS_FILT_HI: begin
            ifc.mask.filter_bits[crx_pkg::ID_W-1:crx_pkg::REG_W] <= WR_DATA[crx_pkg::HI_W-1:0];
            ifc.mask.mask_on_long_id <= WR_DATA[crx_pkg::FH_LONG];
            ifc.mask.mask_on_way_bit <= WR_DATA[crx_pkg::FH_WAY];
          end
          crx_pkg::OFS_IDENT_LO: begin
            ifc.arb.ident[crx_pkg::REG_W-1:0] <= WR_DATA[crx_pkg::REG_W-1:0];
          end
          crx_pkg::OFS_IDENT_HI: begin
            ifc.arb.ident[crx_pkg::ID_W-1:crx_pkg::REG_W] <= WR_DATA[crx_pkg::HI_W-1:0];
            ifc.arb.object_in_use <= WR_DATA[crx_pkg::IH_USE];
            ifc.arb.long_identifier_flag <= WR_DATA[crx_pkg::IH_LONG];
            ifc.arb.way_bit <= WR_DATA[crx_pkg::IH_WAY];
          end
          crx_pkg::OFS_CONTROL: begin
            ifc.ctl.fresh_content_flag <= WR_DATA[crx_pkg::CT_FRESH];
            ifc.ctl.overrun_flag <= WR_DATA[crx_pkg::CT_OVER];
            ifc.ctl.irq_waiting <= WR_DATA[crx_pkg::CT_IRQ];
            ifc.ctl.filter_enable <= WR_DATA[crx_pkg::CT_FILT];
            ifc.ctl.send_irq_enable <= WR_DATA[crx_pkg::CT_TXIE];
            ifc.ctl.receive_irq_enable <= WR_DATA[crx_pkg::CT_RECEIVE_IRQ_ENABLE];
            ifc.ctl.auto_answer_enable <= WR_DATA[crx_pkg::CT_AUTO];
            ifc.ctl.send_pending <= WR_DATA[crx_pkg::CT_SEND];
            ifc.ctl.last_in_chain <= WR_DATA[crx_pkg::CT_LAST];
            ifc.ctl.dlc <= WR_DATA[crx_pkg::DLC_W-1:0];
          end
          // frame byte 0 lands in bits 7..0 of the first payload word
          crx_pkg::OFS_PAY_A1: begin
            ifc.payload[0 +: crx_pkg::REG_W] <= WR_DATA[crx_pkg::REG_W-1:0];
          end
          crx_pkg::OFS_PAY_A2: begin
            ifc.payload[16 +: crx_pkg::REG_W] <= WR_DATA[crx_pkg::REG_W-1:0];
          end
          crx_pkg::OFS_PAY_B1: begin
            ifc.payload[32 +: crx_pkg::REG_W] <= WR_DATA[crx_pkg::REG_W-1:0];
          end
          crx_pkg::OFS_PAY_B2: begin
            ifc.payload[48 +: crx_pkg::REG_W] <= WR_DATA[crx_pkg::REG_W-1:0];
          end
          default: begin
          end
        endcase
      end
      if (cmd_go) begin
        object_select <= cmd_num;
        // a fetch shows the flags as they stood before any clear
        if (!sel[crx_pkg::SEL_STORE]) begin
          ifc <= merge(ifc, obj[cmd_idx], sel);
        end
      end
    end
  end

  always_comb begin
    next_rd = '0;
    case (ADDR)
      crx_pkg::OFS_SELECT: next_rd[crx_pkg::SEL_W-1:0] = sel;
      crx_pkg::OFS_COMMAND: next_rd[crx_pkg::NUM_W-1:0] = object_select;
      crx_pkg::OFS_FILT_LO: next_rd[crx_pkg::REG_W-1:0] = ifc.mask.filter_bits[crx_pkg::REG_W-1:0];
      crx_pkg::OFS_FILT_HI: begin
        next_rd[crx_pkg::HI_W-1:0] = ifc.mask.filter_bits[crx_pkg::ID_W-1:crx_pkg::REG_W];
        next_rd[crx_pkg::FH_LONG] = ifc.mask.mask_on_long_id;
        next_rd[crx_pkg::FH_WAY] = ifc.mask.mask_on_way_bit;
      end
      crx_pkg::OFS_IDENT_LO: next_rd[crx_pkg::REG_W-1:0] = ifc.arb.ident[crx_pkg::REG_W-1:0];
      crx_pkg::OFS_IDENT_HI: begin
        next_rd[crx_pkg::HI_W-1:0] = ifc.arb.ident[crx_pkg::ID_W-1:crx_pkg::REG_W];
        next_rd[crx_pkg::IH_USE] = ifc.arb.object_in_use;
        next_rd[crx_pkg::IH_LONG] = ifc.arb.long_identifier_flag;
        next_rd[crx_pkg::IH_WAY] = ifc.arb.way_bit;
      end
      crx_pkg::OFS_CONTROL: next_rd[crx_pkg::REG_W-1:0] = ctl_word(ifc.ctl);
      crx_pkg::OFS_PAY_A1: next_rd[crx_pkg::REG_W-1:0] = ifc.payload[0 +: crx_pkg::REG_W];
      crx_pkg::OFS_PAY_A2: next_rd[crx_pkg::REG_W-1:0] = ifc.payload[16 +: crx_pkg::REG_W];
      crx_pkg::OFS_PAY_B1: next_rd[crx_pkg::REG_W-1:0] = ifc.payload[32 +: crx_pkg::REG_W];
      crx_pkg::OFS_PAY_B2: next_rd[crx_pkg::REG_W-1:0] = ifc.payload[48 +: crx_pkg::REG_W];
      crx_pkg::OFS_PENDING: next_rd[NUM_OBJ-1:0] = pend;
      crx_pkg::OFS_FRESH: next_rd[NUM_OBJ-1:0] = fresh_vec;
      crx_pkg::OFS_IRQ: next_rd[NUM_OBJ-1:0] = irq_vec;
      default: next_rd = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      RD_DATA <= '0;
    end else if (CE) begin
      RD_DATA <= RD_STB ? next_rd : '0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      RX_MATCH <= 1'b0;
      RX_OBJECT <= '0;
    end else if (CE) begin
      RX_MATCH <= rx_go;
      RX_OBJECT <= rx_go ? crx_pkg::NUM_W'(rx_idx) + 6'h01 : '0;
    end
  end

  // object order, not identifier, decides what goes out first
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      TX_REQUEST <= 1'b0;
      TX_OBJECT <= '0;
      TX_FRAME <= '0;
    end else if (CE) begin
      TX_REQUEST <= tx_found;
      TX_OBJECT <= crx_pkg::NUM_W'(tx_idx) + 6'h01;
      TX_FRAME.ident <= obj[tx_idx].arb.ident;
      TX_FRAME.long_identifier_flag <= obj[tx_idx].arb.long_identifier_flag;
      TX_FRAME.remote <= !obj[tx_idx].arb.way_bit;
      TX_FRAME.dlc <= obj[tx_idx].ctl.dlc;
      TX_FRAME.payload <= obj[tx_idx].payload;
    end
  end
endmodule : crx_handler

/* File: dv/crx_props.sv */
/*
  crx_props: port-level checks of crx_handler.
  Assumes CE is held high and the bind below this module.
*/
module crx_props #(
  parameter int NUM_OBJ = 32
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [31:0] RD_DATA,
  // frames
  input wire logic RX_VALID,
  input wire logic RX_MATCH,
  input wire logic [5:0] RX_OBJECT,
  input wire logic TX_REQUEST,
  input wire logic [5:0] TX_OBJECT,
  input wire logic TX_DONE,
  input wire logic [5:0] TX_DONE_OBJECT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  sequence s_done;
    TX_DONE && TX_REQUEST && TX_DONE_OBJECT == TX_OBJECT;
  endsequence
  sequence s_quiet;
    !TX_DONE && !WR_STB && !RX_VALID;
  endsequence
  a_read_idle: assert property (!$past(RD_STB) |-> RD_DATA == 32'h0)
    else $error("read data outside its slot");
  a_read_unmapped: assert property (RD_STB && ADDR == 8'hFC |=> RD_DATA == 32'h0)
    else $error("unmapped read not zero");
  a_match_cause: assert property (RX_MATCH |-> $past(RX_VALID))
    else $error("match without a frame");
  a_match_object: assert property (RX_MATCH |-> RX_OBJECT >= 1 && RX_OBJECT <= NUM_OBJ)
    else $error("matched object out of range");
  a_object_idle: assert property (!RX_MATCH |-> RX_OBJECT == 6'h00)
    else $error("object number without match");
  a_send_range: assert property (TX_REQUEST |-> TX_OBJECT >= 1 && TX_OBJECT <= NUM_OBJ)
    else $error("send object out of range");
  a_send_order: assert property (s_done |-> ##2 (!TX_REQUEST || TX_OBJECT > $past(TX_OBJECT, 2)))
    else $error("send order not ascending");
  a_send_hold: assert property (s_quiet ##1 (s_quiet and TX_REQUEST) |-> ##2 TX_REQUEST)
    else $error("send request dropped");
  a_reset_quiet: assert property ($past(RESET) |-> !RX_MATCH && !TX_REQUEST && RD_DATA == 32'h0)
    else $error("outputs active after reset");
endmodule : crx_props

bind crx_handler crx_props #(.NUM_OBJ(NUM_OBJ)) u_props (.CORE_CLK(CORE_CLK), .RESET(RESET),
  .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .RX_VALID(RX_VALID),
  .RX_MATCH(RX_MATCH), .RX_OBJECT(RX_OBJECT), .TX_REQUEST(TX_REQUEST), .TX_OBJECT(TX_OBJECT),
  .TX_DONE(TX_DONE), .TX_DONE_OBJECT(TX_DONE_OBJECT));

/* File: dv/crx_node.sv */
/*
  crx_node: the far nodes as the handler sees them: whole frames in, and a
  transmit engine that answers requests. Assumes CORE_CLK from the bench.
*/
module crx_node (
  // clock
  input wire logic CORE_CLK,
  // frames towards the handler
  output logic RX_VALID,
  output crx_pkg::crx_frame_t RX_FRAME,
  // transmit engine
  input wire logic TX_REQUEST,
  input wire logic [5:0] TX_OBJECT,
  output logic TX_DONE,
  output logic [5:0] TX_DONE_OBJECT
);
  timeunit 1ns;
  timeprecision 1ns;
  bit go = 1'b0;
  int lag = 3;
  logic [5:0] sent [$];
  initial begin
    RX_VALID = 1'b0;
    RX_FRAME = '0;
    TX_DONE = 1'b0;
    TX_DONE_OBJECT = 6'h00;
  end
  // released frame lines show the inverse so stale values never pass
  task automatic send(input crx_pkg::crx_frame_t fr);
    @(posedge CORE_CLK);
    RX_VALID <= 1'b1;
    RX_FRAME <= fr;
    @(posedge CORE_CLK);
    RX_VALID <= 1'b0;
    RX_FRAME <= ~fr;
  endtask : send
  // the object is latched at start, so a later preemption is not followed
  always begin : engine
    logic [5:0] k;
    @(posedge CORE_CLK);
    if (go && TX_REQUEST === 1'b1) begin
      k = TX_OBJECT;
      repeat (lag) @(posedge CORE_CLK);
      TX_DONE <= 1'b1;
      TX_DONE_OBJECT <= k;
      sent.push_back(k);
      @(posedge CORE_CLK);
      TX_DONE <= 1'b0;
      TX_DONE_OBJECT <= ~k;
      repeat (2) @(posedge CORE_CLK);
    end
  end
endmodule : crx_node

/* File: dv/crx_handler_tb.sv */
/*
  crx_handler_tb: drives the register port, feeds frames through the node
  model and compares match results and object state with a scan model.
  Assumes eight objects and CE held high.
*/
module crx_handler_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 8;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic WR_STB = 1'b0;
  logic RD_STB = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WR_DATA = 32'h0;
  logic [31:0] RD_DATA, rv, ctl;
  logic RX_VALID, RX_MATCH, TX_REQUEST, TX_DONE;
  logic [5:0] RX_OBJECT, TX_OBJECT, TX_DONE_OBJECT;
  crx_pkg::crx_frame_t RX_FRAME, TX_FRAME, f;
  int n_errors = 0;
  int check_count = 0;
  int seed = 61;
  int want;
  logic [28:0] m_id [1:6], m_msk [1:6];
  bit m_fen [1:6], m_ml [1:6], m_mw [1:6], m_lg [1:6], m_dir [1:6], m_fr [1:6], m_ov [1:6];
  logic [15:0] m_pay [1:6];
  always #10 CORE_CLK = ~CORE_CLK;
  crx_handler #(.NUM_OBJ(N)) u_crx_handler (.CORE_CLK(CORE_CLK), .RESET(RESET), .CE(1'b1),
    .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
    .RX_VALID(RX_VALID), .RX_FRAME(RX_FRAME), .RX_MATCH(RX_MATCH), .RX_OBJECT(RX_OBJECT),
    .TX_REQUEST(TX_REQUEST), .TX_OBJECT(TX_OBJECT), .TX_FRAME(TX_FRAME), .TX_DONE(TX_DONE),
    .TX_DONE_OBJECT(TX_DONE_OBJECT));
  crx_node u_node (.CORE_CLK(CORE_CLK), .RX_VALID(RX_VALID), .RX_FRAME(RX_FRAME),
    .TX_REQUEST(TX_REQUEST), .TX_OBJECT(TX_OBJECT), .TX_DONE(TX_DONE),
    .TX_DONE_OBJECT(TX_DONE_OBJECT));
  task automatic print_verdict;
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] exp, got);
    check_count++;
    if (exp !== got) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge CORE_CLK);
    WR_STB <= 1'b0;
    WR_DATA <= $random(seed);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CORE_CLK);
    RD_STB <= 1'b0;
    #1;
    rv = RD_DATA;
  endtask : rd
  task automatic cfg(input int n, input logic [15:0] mh, ml, ih, il, ct, pay);
    wr(8'h08, {16'h0, ml});
    wr(8'h0C, {16'h0, mh});
    wr(8'h10, {16'h0, il});
    wr(8'h14, {16'h0, ih});
    wr(8'h18, {16'h0, ct});
    wr(8'h1C, {16'h0, pay});
    wr(8'h00, 32'hF3);
    wr(8'h04, 32'(n));
    m_id[n] = {ih[12:0], il};
    m_msk[n] = {mh[12:0], ml};
    {m_ml[n], m_mw[n]} = mh[15:14];
    {m_lg[n], m_dir[n]} = ih[14:13];
    m_fen[n] = ct[12];
    m_pay[n] = pay;
  endtask : cfg
  task automatic fetch(input int n);
    wr(8'h00, 32'h72);
    wr(8'h04, 32'(n));
    rd(8'h18);
    ctl = rv;
    rd(8'h1C);
  endtask : fetch
  // first object in ascending order whose filter accepts the frame
  function automatic int best(input crx_pkg::crx_frame_t fr);
    logic [28:0] m;
    for (int k = 1; k <= 6; k++) begin
      m = m_fen[k] ? m_msk[k] : '1;
      // a standard identifier leaves the low eighteen identifier bits out of the test
      if (!fr.long_identifier_flag) begin
        m[17:0] = '0;
      end
      if (((fr.ident ^ m_id[k]) & m) == 29'h0 &&
          ((m_fen[k] && !m_ml[k]) || fr.long_identifier_flag == m_lg[k]) &&
          ((m_fen[k] && !m_mw[k]) || fr.remote == m_dir[k])) begin
        return k;
      end
    end
    return 0;
  endfunction : best
  task automatic rx(input crx_pkg::crx_frame_t fr);
    u_node.send(fr);
    #1;
    want = best(fr);
    check("rx match", want != 0, RX_MATCH);
    check("rx object", want, RX_OBJECT);
    if (want > 0 && !fr.remote) begin
      m_ov[want] = m_ov[want] | m_fr[want];
      m_fr[want] = 1'b1;
      m_pay[want] = fr.payload[15:0];
    end
  endtask : rx
  task automatic wait_sent(input int cnt);
    for (int i = 0; i < 400 && u_node.sent.size() < cnt; i++) @(posedge CORE_CLK);
    if (u_node.sent.size() < cnt) begin
      n_errors++;
      $display("Error send count expected %0d seen %0d", cnt, u_node.sent.size());
      print_verdict();
    end
  endtask : wait_sent
  initial begin
    repeat (4) @(posedge CORE_CLK);
    RESET <= 1'b0;
    cfg(1, 16'h0000, 16'h0000, 16'hA2D4, 16'h0000, 16'h0288, 16'h1111);
    cfg(2, 16'h0000, 16'h0000, 16'hA30C, 16'h0000, 16'h0088, 16'h2222);
    cfg(3, 16'hDFFF, 16'hFFFF, 16'hA35C, 16'h0000, 16'h1088, 16'h3333);
    cfg(4, 16'h0000, 16'h0000, 16'h848C, 16'h0000, 16'h0488, 16'h4444);
    cfg(5, 16'hDFFF, 16'h0000, 16'hCABC, 16'h1234, 16'h1088, 16'h5555);
    cfg(6, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h1488, 16'h6666);
    rd(8'hFC);
    check("unmapped read", 32'h0, rv);
    for (int i = 0; i < 40; i++) begin
      f = '0;
      f.dlc = 4'h8;
      f.payload = {$random(seed), $random(seed)};
      case ($unsigned($random(seed)) % 4)
        0: f.ident = {11'h123, 18'h0};
        1: begin
          f.ident = {13'h0ABC, 16'($random(seed))};
          f.long_identifier_flag = 1'b1;
        end
        2: f.ident = {13'h0ABC, 16'h0};
        default: begin
          f.ident = 29'($random(seed));
          f.long_identifier_flag = 1'($random(seed));
        end
      endcase
      rx(f);
    end
    for (int k = 4; k <= 6; k++) begin
      fetch(k);
      check("rx flags", {m_fr[k], m_ov[k], m_fr[k] & (k != 5)}, ctl[15:13]);
      check("rx bytes", m_pay[k], rv);
    end
    for (int k = 3; k >= 1; k--) begin
      wr(8'h00, 32'h84);
      wr(8'h04, 32'(k));
    end
    u_node.lag = 20;
    // the last request needs two edges to reach TX_OBJECT before the engine looks
    repeat (2) @(posedge CORE_CLK);
    u_node.go = 1'b1;
    wait_sent(3);
    for (int k = 0; k < 3; k++) begin
      check("send order", k + 1, u_node.sent[k]);
    end
    u_node.lag = 0;
    f = '0;
    f.remote = 1'b1;
    f.dlc = 4'h8;
    f.ident = {11'h0B5, 18'h0};
    rx(f);
    wait_sent(4);
    check("answer object", 1, u_node.sent[3]);
    fetch(1);
    check("answered ctl", 32'h0288, ctl);
    f.ident = {11'h0C3, 18'h0};
    rx(f);
    fetch(2);
    check("ignored ctl", 32'h0088, ctl);
    check("ignored send", 4, u_node.sent.size());
    u_node.go = 1'b0;
    wr(8'h00, 32'h84);
    wr(8'h04, 32'h3);
    f.ident = {11'h0D7, 18'h0};
    f.dlc = 4'h5;
    rx(f);
    fetch(3);
    check("masked ctl", 32'h9085, ctl);
    check("masked bytes", 32'h3333, rv);
    check("masked request", 0, TX_REQUEST);
    wr(8'h1C, 32'h7777);
    wr(8'h00, 32'h86);
    wr(8'h04, 32'h3);
    repeat (2) @(posedge CORE_CLK);
    #1;
    check("send frame", {1'b0, f.ident[28:18], f.dlc, 16'h7777},
      {TX_FRAME.remote, TX_FRAME.ident[28:18], TX_FRAME.dlc, TX_FRAME.payload[15:0]});
    u_node.go = 1'b1;
    wait_sent(5);
    check("software answer", 3, u_node.sent[4]);
    print_verdict();
  end
endmodule : crx_handler_tb
